// ---- hw/pml_top.sv ----
/*
  map-driven pwm control for four low-power outputs, with apb register access.
  assumes event_on comes from logic on pclk; axis inputs and currents come from outside.
*/
`include "pml_regs.svh"

module pml_top #(
  parameter int CLK_HZ = `PML_CLK_HZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] engine_speed_input,
  input wire logic [15:0] throttle_position_input,
  input wire logic [15:0] aux_input_a,
  input wire logic [15:0] aux_input_b,
  input wire logic [3:0][15:0] load_current_ma,
  input wire logic [3:0] event_on,
  output logic pwm_channel_one,
  output logic pwm_channel_two,
  output logic pwm_channel_three,
  output logic pwm_channel_four
);

  localparam int PER_MIN = CLK_HZ / 15000;
  localparam int PER_MAX = CLK_HZ / 30;
  localparam int PER_RST = CLK_HZ / 1000;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // fixed duty is clamped at write so software never sees an illegal value
  function automatic logic [7:0] fdt_clamp(input logic [31:0] d);
    if (d < 32'(`PML_DMIN)) return `PML_DMIN;
    if (d > 32'(`PML_DMAX)) return `PML_DMAX;
    return d[7:0];
  endfunction

  // frequency types on channels one and two fall back to disabled
  function automatic pml_pkg::pml_cfg_s cfg_fix(input logic [11:0] d, input int k);
    pml_pkg::pml_cfg_s r;
    r = pml_pkg::pml_cfg_s'(d);
    if (d[3:0] > 4'h9 || (k < 2 && d[3:0] >= 4'h6)) begin
      r.typ = pml_pkg::PML_NONE;
    end
    return r;
  endfunction

  // bracket an input between breakpoints; relies on increasing breakpoints
  function automatic pml_pkg::pml_axis_s axis_find(
    input logic [3:0][15:0] bp,
    input logic [1:0] nm1,
    input logic [15:0] v
  );
    pml_pkg::pml_axis_s a;
    logic [15:0] vc;
    vc = (v < bp[0]) ? bp[0] : ((v > bp[nm1]) ? bp[nm1] : v);
    a.idx = 2'h0;
    for (int i = 1; i < 4; i++) begin
      if (2'(i) <= nm1 && vc >= bp[i]) begin
        a.idx = 2'(i);
      end
    end
    a.num = vc - bp[a.idx];
    a.den = (a.idx == nm1) ? 16'h0001 : bp[a.idx + 2'h1] - bp[a.idx];
    return a;
  endfunction

  // weight between two breakpoints, 256 meaning fully the upper one
  function automatic logic [8:0] frac_eff(
    input logic [7:0] f,
    input pml_pkg::pml_type_e t,
    input logic nz
  );
    unique case (t)
      pml_pkg::PML_DINT, pml_pkg::PML_FINT: return {1'b0, f};
      pml_pkg::PML_DUP, pml_pkg::PML_FUP: return nz ? 9'h100 : 9'h000;
      pml_pkg::PML_DNR, pml_pkg::PML_FNR: return f[7] ? 9'h100 : 9'h000;
      default: return 9'h000;
    endcase
  endfunction

  function automatic logic [15:0] lerp(
    input logic [15:0] a,
    input logic [15:0] b,
    input logic [8:0] f
  );
    logic [24:0] s;
    s = a * (9'h100 - f) + b * f;
    return s[23:8];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  logic [3:0][15:0] in_s1_r;
  logic [3:0][15:0] in_s2_r;
  logic [3:0][15:0] cur_s1_r;
  logic [3:0][15:0] cur_s2_r;

  // two flops each; values are treated as slow levels, no word handshake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_s1_r <= '0;
      in_s2_r <= '0;
      cur_s1_r <= '0;
      cur_s2_r <= '0;
    end else begin
      in_s1_r <= {aux_input_b, aux_input_a, throttle_position_input, engine_speed_input};
      in_s2_r <= in_s1_r;
      cur_s1_r <= load_current_ma;
      cur_s2_r <= cur_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb registers and tables

  logic man_r, man_nxt;
  logic [3:0] mst_r, mst_nxt;
  logic [2:0][15:0] frq_r, frq_nxt;
  logic [1:0][7:0] fdt_r, fdt_nxt;
  pml_pkg::pml_cfg_s [3:0] cfg_r, cfg_nxt;
  logic [3:0][7:0][15:0] bp_r, bp_nxt;
  logic [3:0][15:0][15:0] map_r, map_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt;
  logic [3:0][7:0] duty_r;
  logic [31:0] rd;
  logic hit, wr, tbl, tbp, tmp;
  logic [1:0] tch;

  assign wr = psel & penable & pready & pwrite;
  assign tbl = paddr[11:10] == `PML_TBL_RGN;
  assign tbp = tbl && paddr[7:5] == 3'h0;
  assign tmp = tbl && paddr[7:6] == 2'h1;
  assign tch = paddr[9:8];

  // decode once for read data, error and write; one wait-free access phase
  always_comb begin
    man_nxt = man_r;
    mst_nxt = mst_r;
    frq_nxt = frq_r;
    fdt_nxt = fdt_r;
    cfg_nxt = cfg_r;
    bp_nxt = bp_r;
    map_nxt = map_r;
    rd = '0;
    hit = 1'b1;
    if (tbp) begin
      rd = {16'h0000, bp_r[tch][paddr[4:2]]};
      if (wr) bp_nxt[tch][paddr[4:2]] = pwdata[15:0];
    end else if (tmp) begin
      rd = {16'h0000, map_r[tch][paddr[5:2]]};
      if (wr) map_nxt[tch][paddr[5:2]] = pwdata[15:0];
    end else if (tbl) begin
      hit = 1'b0;
    end else begin
      case (paddr)
        `PML_CTRL_OFS: begin
          rd = {31'h0, man_r};
          if (wr) man_nxt = pwdata[0];
          if (wr && pwdata[0] && !man_r) mst_nxt = 4'h0;
        end
        `PML_MCMD_OFS: begin
          rd = {28'h0, mst_r};
          if (wr && man_r) mst_nxt = mst_r ^ pwdata[3:0];
        end
        `PML_FRQ12_OFS: begin
          rd = {16'h0000, frq_r[0]};
          if (wr) frq_nxt[0] = pwdata[15:0];
        end
        `PML_FRQ3_OFS: begin
          rd = {16'h0000, frq_r[1]};
          if (wr) frq_nxt[1] = pwdata[15:0];
        end
        `PML_FRQ4_OFS: begin
          rd = {16'h0000, frq_r[2]};
          if (wr) frq_nxt[2] = pwdata[15:0];
        end
        `PML_FDT3_OFS: begin
          rd = {24'h0, fdt_r[0]};
          if (wr) fdt_nxt[0] = fdt_clamp(pwdata);
        end
        `PML_FDT4_OFS: begin
          rd = {24'h0, fdt_r[1]};
          if (wr) fdt_nxt[1] = fdt_clamp(pwdata);
        end
        default: hit = 1'b0;
      endcase
      for (int k = 0; k < 4; k++) begin
        if (paddr == `PML_CFG_OFS + 12'(4 * k)) begin
          hit = 1'b1;
          rd = {20'h0, cfg_r[k]};
          if (wr) cfg_nxt[k] = cfg_fix(pwdata[11:0], k);
        end
        if (paddr == `PML_CUR_OFS + 12'(4 * k)) begin
          hit = 1'b1;
          rd = {16'h0000, cur_s2_r[k]};
        end
        if (paddr == `PML_DUTY_OFS + 12'(4 * k)) begin
          hit = 1'b1;
          rd = {24'h0, duty_r[k]};
        end
      end
    end
    pready_nxt = psel & ~penable;
    pslverr_nxt = psel & ~penable & ~hit;
    prdata_nxt = (psel && !penable && !pwrite) ? rd : prdata;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      man_r <= 1'b0;
      mst_r <= 4'h0;
      frq_r <= {3{`PML_FREQ_RST}};
      fdt_r <= {2{`PML_FDT_RST}};
      cfg_r <= '0;
      bp_r <= '0;
      map_r <= '0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      man_r <= man_nxt;
      mst_r <= mst_nxt;
      frq_r <= frq_nxt;
      fdt_r <= fdt_nxt;
      cfg_r <= cfg_nxt;
      bp_r <= bp_nxt;
      map_r <= map_nxt;
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lookup engine: one channel at a time, one shared serial divider

  pml_pkg::pml_state_e state_r, state_nxt;
  logic [1:0] ch_r, ch_nxt;
  pml_pkg::pml_axis_s ax_r, ax_nxt, ay_r, ay_nxt;
  logic [8:0] fx_r, fx_nxt, fy_r, fy_nxt;
  logic [24:0] dv_r, dv_nxt, q_r, q_nxt;
  logic [16:0] rem_r, rem_nxt, r1;
  logic [15:0] den_r, den_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  pml_pkg::pml_per_t [3:0] per_r, per_nxt;
  logic [3:0][7:0] duty_nxt;
  pml_pkg::pml_cfg_s cc;
  logic ge, done, freqm;
  logic [24:0] qf;
  logic [15:0] r0, r1row, dlin, fsrc, fq;
  logic [1:0] ix1, iy1, fidx;

  assign cc = cfg_r[ch_r];
  assign freqm = cc.typ >= pml_pkg::PML_FINT;
  assign r1 = {rem_r[15:0], dv_r[24]};
  assign ge = r1 >= {1'b0, den_r};
  assign qf = {q_r[23:0], ge};
  assign done = cnt_r == `PML_DIV_LAST;
  assign ix1 = ax_r.idx + 2'h1;
  assign iy1 = ay_r.idx + 2'h1;
  // bilinear blend; in frequency mode the y index is zero so r0 is the result
  assign r0 = lerp(map_r[ch_r][{ay_r.idx, ax_r.idx}], map_r[ch_r][{ay_r.idx, ix1}], fx_r);
  assign r1row = lerp(map_r[ch_r][{iy1, ax_r.idx}], map_r[ch_r][{iy1, ix1}], fx_r);
  assign dlin = lerp(r0, r1row, fy_r);
  assign fidx = (ch_r < 2'h2) ? 2'h0 : ch_r - 2'h1;
  assign fsrc = freqm ? r0 : frq_r[fidx];
  assign fq = (fsrc < `PML_FMIN_HZ) ? `PML_FMIN_HZ :
              ((fsrc > `PML_FMAX_HZ) ? `PML_FMAX_HZ : fsrc);

  // a fresh lookup per channel costs about 76 cycles, so outputs lag inputs
  always_comb begin
    state_nxt = state_r;
    ch_nxt = ch_r;
    ax_nxt = ax_r;
    ay_nxt = ay_r;
    fx_nxt = fx_r;
    fy_nxt = fy_r;
    per_nxt = per_r;
    duty_nxt = duty_r;
    dv_nxt = {dv_r[23:0], 1'b0};
    rem_nxt = ge ? r1 - {1'b0, den_r} : r1;
    q_nxt = qf;
    den_nxt = den_r;
    cnt_nxt = cnt_r + 5'h01;
    unique case (state_r)
      pml_pkg::PML_S_FIND: begin
        ax_nxt = axis_find(bp_r[ch_r][3:0], cc.nx_m1, in_s2_r[cc.xsel]);
        ay_nxt = axis_find(bp_r[ch_r][7:4], freqm ? 2'h0 : cc.ny_m1,
                           in_s2_r[cc.ysel]);
        dv_nxt = {1'b0, ax_nxt.num, 8'h00};
        den_nxt = ax_nxt.den;
        rem_nxt = '0;
        cnt_nxt = '0;
        state_nxt = pml_pkg::PML_S_DIVX;
      end
      pml_pkg::PML_S_DIVX: begin
        if (done) begin
          fx_nxt = frac_eff(qf[7:0], cc.typ, ax_r.num != 16'h0000);
          dv_nxt = {1'b0, ay_r.num, 8'h00};
          den_nxt = ay_r.den;
          rem_nxt = '0;
          cnt_nxt = '0;
          state_nxt = pml_pkg::PML_S_DIVY;
        end
      end
      pml_pkg::PML_S_DIVY: begin
        if (done) begin
          fy_nxt = frac_eff(qf[7:0], cc.typ, ay_r.num != 16'h0000);
          dv_nxt = 25'(CLK_HZ);
          den_nxt = fq;
          rem_nxt = '0;
          cnt_nxt = '0;
          state_nxt = pml_pkg::PML_S_DIVP;
        end
      end
      pml_pkg::PML_S_DIVP: begin
        if (done) begin
          if (ch_r != 2'h1) per_nxt[ch_r] = qf[19:0];
          if (ch_r == 2'h0) per_nxt[1] = qf[19:0];
          duty_nxt[ch_r] = freqm ? fdt_r[ch_r[0]] :
                           ((dlin > `PML_DUTY_FULL) ? 8'h64 : dlin[7:0]);
          ch_nxt = ch_r + 2'h1;
          state_nxt = pml_pkg::PML_S_FIND;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= pml_pkg::PML_S_FIND;
      ch_r <= 2'h0;
      ax_r <= '0;
      ay_r <= '0;
      fx_r <= '0;
      fy_r <= '0;
      dv_r <= '0;
      rem_r <= '0;
      q_r <= '0;
      den_r <= 16'h0001;
      cnt_r <= '0;
      per_r <= {4{20'(PER_RST)}};
      duty_r <= '0;
    end else begin
      state_r <= state_nxt;
      ch_r <= ch_nxt;
      ax_r <= ax_nxt;
      ay_r <= ay_nxt;
      fx_r <= fx_nxt;
      fy_r <= fy_nxt;
      dv_r <= dv_nxt;
      rem_r <= rem_nxt;
      q_r <= q_nxt;
      den_r <= den_nxt;
      cnt_r <= cnt_nxt;
      per_r <= per_nxt;
      duty_r <= duty_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pwm counters and output drive

  pml_pkg::pml_per_t [3:0] pcnt_r, pcnt_nxt;
  logic [3:0] out_nxt;
  logic [3:0] out_q;

  assign out_q = {pwm_channel_four, pwm_channel_three, pwm_channel_two, pwm_channel_one};

  // channel two mirrors channel one's counter so their rising edges stay aligned
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      pcnt_nxt[k] = (pcnt_r[k] >= per_r[k] - 20'h00001) ? 20'h00000 : pcnt_r[k] + 20'h00001;
      out_nxt[k] = 1'b0;
      if (man_r) begin
        out_nxt[k] = mst_r[k];
      end else if (event_on[k]) begin
        unique case (cfg_r[k].typ)
          pml_pkg::PML_NONE: out_nxt[k] = 1'b0;
          pml_pkg::PML_DIG: out_nxt[k] = 1'b1;
          default: out_nxt[k] = 27'(pcnt_r[k]) * 27'd100 < 27'(per_r[k]) * 27'(duty_r[k]);
        endcase
      end
    end
    pcnt_nxt[1] = pcnt_nxt[0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcnt_r <= '0;
      pwm_channel_one <= 1'b0;
      pwm_channel_two <= 1'b0;
      pwm_channel_three <= 1'b0;
      pwm_channel_four <= 1'b0;
    end else begin
      pcnt_r <= pcnt_nxt;
      pwm_channel_one <= out_nxt[0];
      pwm_channel_two <= out_nxt[1];
      pwm_channel_three <= out_nxt[2];
      pwm_channel_four <= out_nxt[3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_man_off;
    $rose(man_r) |=> out_q == 4'h0;
  endproperty
  a_man_off: assert property (p_man_off) else $error("manual entry left a channel on");

  property p_toggle;
    (wr && paddr == `PML_MCMD_OFS && man_r) |=> mst_r == ($past(mst_r) ^ $past(pwdata[3:0]));
  endproperty
  a_toggle: assert property (p_toggle) else $error("manual command did not toggle");

  property p_fdt;
    fdt_r[0] >= `PML_DMIN && fdt_r[0] <= `PML_DMAX && fdt_r[1] >= `PML_DMIN &&
    fdt_r[1] <= `PML_DMAX;
  endproperty
  a_fdt: assert property (p_fdt) else $error("fixed duty out of range");

  property p_per;
    per_r[0] >= 20'(PER_MIN) && per_r[0] <= 20'(PER_MAX) && per_r[2] >= 20'(PER_MIN) &&
    per_r[2] <= 20'(PER_MAX) && per_r[3] >= 20'(PER_MIN) && per_r[3] <= 20'(PER_MAX);
  endproperty
  a_per: assert property (p_per) else $error("applied period out of range");

  property p_share;
    per_r[0] == per_r[1] && pcnt_r[0] == pcnt_r[1];
  endproperty
  a_share: assert property (p_share) else $error("channels one and two diverged");

  property p_nofreq;
    cfg_r[0].typ < pml_pkg::PML_FINT && cfg_r[1].typ < pml_pkg::PML_FINT;
  endproperty
  a_nofreq: assert property (p_nofreq) else $error("frequency type on channel one or two");

  property p_fduty;
    (state_r == pml_pkg::PML_S_DIVP && done && ch_r == 2'h2 && freqm) |=>
      duty_r[2] == $past(fdt_r[0]);
  endproperty
  a_fduty: assert property (p_fduty) else $error("frequency mode duty not fixed");

  property p_cur;
    (psel && !penable && !pwrite && paddr == `PML_CUR_OFS) |=>
      prdata == {16'h0000, $past(cur_s2_r[0])};
  endproperty
  a_cur: assert property (p_cur) else $error("current readback wrong");

  property p_none;
    (!man_r && cfg_r[0].typ == pml_pkg::PML_NONE) |=> !pwm_channel_one;
  endproperty
  a_none: assert property (p_none) else $error("disabled channel driven");

  property p_clamp;
    state_r == pml_pkg::PML_S_DIVX |-> ax_r.num < ax_r.den;
  endproperty
  a_clamp: assert property (p_clamp) else $error("axis input not bracketed");

  c_toggle: cover property (wr && paddr == `PML_MCMD_OFS && man_r);
  c_freq: cover property (state_r == pml_pkg::PML_S_DIVP && done && freqm);
  c_intrp: cover property (fx_r > 9'h000 && fx_r < 9'h100);
  c_pwm: cover property ($rose(pwm_channel_three) ##[1:1000] $fell(pwm_channel_three));

endmodule

// ---- include/pml_regs.svh ----
/*
  register offsets, reset values and timing figures of the map-driven pwm block.
  assumes byte addresses on a 12-bit apb address; each register is one aligned word.
*/
// Function
// - duty mode reads duty from a two-axis table, axes chosen by configuration
// - single-axis duty table uses only the first row or column of other axis
// - applied pwm frequency in duty mode is held between 30 Hz and 15 kHz
// - channels one and two always run from one common period
// - frequency mode takes frequency from a one-axis table at fixed duty
// - frequency mapping exists only on channels three and four
// - fixed duty of frequency mode is kept between 5 and 99 percent
// - the frequency table axis is indexed by a configured input channel
// - manual test mode overrides event control and starts with all channels off
// - each manual on command toggles its channel, first on then off
// - present load current of each channel in milliamperes is readable
// - interpolating types blend linearly between the neighbouring breakpoints
// - other types pick the lower, the higher or the nearest breakpoint
// - a disabled type keeps the output off; digital type is plain on or off
`ifndef PML_REGS_SVH
`define PML_REGS_SVH
`define PML_CTRL_OFS 12'h000
`define PML_MCMD_OFS 12'h004
`define PML_FRQ12_OFS 12'h008
`define PML_FRQ3_OFS 12'h00c
`define PML_FRQ4_OFS 12'h010
`define PML_FDT3_OFS 12'h014
`define PML_FDT4_OFS 12'h018
`define PML_CFG_OFS 12'h020
`define PML_CUR_OFS 12'h030
`define PML_DUTY_OFS 12'h040
`define PML_TBL_RGN 2'h1
`define PML_FREQ_RST 16'h03e8
`define PML_FDT_RST 8'h32
`define PML_CLK_HZ 20000000
`define PML_FMIN_HZ 16'h001e
`define PML_FMAX_HZ 16'h3a98
`define PML_DMIN 8'h05
`define PML_DMAX 8'h63
`define PML_DUTY_FULL 16'h0064
`define PML_DIV_LAST 5'h18
`endif

// ---- include/pml_pkg.sv ----
/*
  types shared by the map-driven pwm block.
  assumes nothing beyond a systemverilog compiler.
*/
package pml_pkg;
  typedef enum logic [3:0] {
    PML_NONE = 4'h0, PML_DIG = 4'h1, PML_DINT = 4'h2, PML_DDN = 4'h3, PML_DUP = 4'h4,
    PML_DNR = 4'h5, PML_FINT = 4'h6, PML_FDN = 4'h7, PML_FUP = 4'h8, PML_FNR = 4'h9
  } pml_type_e;
  typedef struct packed {
    logic [1:0] ny_m1;
    logic [1:0] nx_m1;
    logic [1:0] ysel;
    logic [1:0] xsel;
    pml_type_e typ;
  } pml_cfg_s;
  typedef struct packed {
    logic [1:0] idx;
    logic [15:0] num;
    logic [15:0] den;
  } pml_axis_s;
  typedef enum logic [3:0] {
    PML_S_FIND = 4'h1, PML_S_DIVX = 4'h2, PML_S_DIVY = 4'h4, PML_S_DIVP = 4'h8
  } pml_state_e;
  typedef logic [19:0] pml_per_t;
endpackage

// ---- tb/pml_load_model.sv ----
/*
  behavioural model of the loads behind the four pwm outputs; reports load current in ma.
  assumes the block's four outputs as drive bits and the block's clock and reset.
*/
module pml_load_model #(
  parameter int BASE_MA = 1200
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] drive,
  output logic [3:0][15:0] load_current_ma
);
  timeunit 1ns;
  timeprecision 1ns;
  //////////////////////////////////////////////////////////////////////////////
  // peak hold: off periods are ignored, so a pwm load reads its on current
  always_ff @(posedge pclk or negedge presetn) begin
    for (int k = 0; k < 4; k++) begin
      if (!presetn) begin
        load_current_ma[k] <= 16'h0000;
      end else if (drive[k]) begin
        load_current_ma[k] <= 16'(BASE_MA + 100 * k); // each load draws its own current
      end
    end
  end
endmodule

// ---- tb/pwm_map_lookup_test.sv ----
/*
  self-checking bench of the map-driven pwm block with a reference model and a load model.
  assumes pml_top with the register map of pml_regs.svh; CLK_HZ scaled down 100x.
*/
`include "pml_regs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module pwm_map_lookup_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CLK = 200000;
  localparam int BASE = 1200;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic er;
  logic [15:0] eng = 16'h0;
  logic [15:0] thr = 16'h0;
  logic [15:0] aux_a = 16'h0;
  logic [15:0] aux_b = 16'h0;
  logic [3:0][15:0] cur;
  logic [3:0] ev = 4'h0;
  logic [3:0] outs;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  int xbp[4] = '{1000, 3000, 5000, 7000};
  int ybp[4] = '{10, 40, 70, 100};
  int fbp[4] = '{100, 300, 500, 700};
  int fmap[4] = '{1000, 2000, 4000, 500};
  int dv[3] = '{2, 200, 77};
  int de[3] = '{5, 99, 77};
  int fr[2] = '{20000, 10};
  int cnt[4];
  int typ, ve, vt, va, e0, e1, per, st, m;

  pml_top #(.CLK_HZ(CLK)) pml_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .engine_speed_input(eng), .throttle_position_input(thr), .aux_input_a(aux_a),
    .aux_input_b(aux_b), .load_current_ma(cur), .event_on(ev),
    .pwm_channel_one(outs[0]), .pwm_channel_two(outs[1]),
    .pwm_channel_three(outs[2]), .pwm_channel_four(outs[3])
  );
  pml_load_model #(.BASE_MA(BASE)) pml_load_model_i (
    .pclk(pclk), .presetn(presetn), .drive(outs), .load_current_ma(cur)
  );

  //////////////////////////////////////////////////////////////////////////////
  // clock and watchdog; the run needs about 24000 cycles
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      conclude();
    end
  end

  task automatic conclude();
    if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // apb master; pready, read data and error are all taken at the rising edge that ends access
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input int e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, 32'(e))
  endtask

  // breakpoint pick: down, up (strictly above lower) or nearest (higher at half)
  function automatic int pick(int v, int bp[4], int n, int t);
    int i;
    i = 0;
    if (v < bp[0]) v = bp[0];
    if (v > bp[n-1]) v = bp[n-1];
    for (int j = 1; j < n; j++) if (v >= bp[j]) i = j;
    if (i < n - 1 && v > bp[i] && (t == 4 || (t == 5 && 2 * (v - bp[i]) >= bp[i+1] - bp[i])))
      i++;
    return i;
  endfunction

  // one axis' share of a linear map with step s per breakpoint; 8-bit blend fraction
  function automatic int axv(int v, int bp[4], int t, int s);
    int i, c;
    i = pick(v, bp, 4, t);
    c = (v < bp[0]) ? bp[0] : ((v > bp[3]) ? bp[3] : v);
    if (t == 2 && i < 3) return s * i + s * ((c - bp[i]) * 256 / (bp[i+1] - bp[i])) / 256;
    return s * i;
  endfunction

  // high cycles in one period of the block's compare
  function automatic int hic(int p, int d);
    int c;
    c = 0;
    for (int k = 0; k < p; k++) if (k * 100 < p * d) c++;
    return c;
  endfunction

  task automatic meas(input int n);
    cnt = '{0, 0, 0, 0};
    // skip the cycle that still shows the output chosen before the last write
    @(posedge pclk);
    repeat (n) begin
      @(negedge pclk);
      for (int k = 0; k < 4; k++) cnt[k] += int'(outs[k]);
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(32'ha82d));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rchk(`PML_FRQ12_OFS, 1000);
    rchk(`PML_FDT3_OFS, 50);
    rchk(12'h0fc, 0);
    `CHK(er, 1'b1)
    // fixed duty is clamped at both ends
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, `PML_FDT4_OFS, 32'(dv[k]));
      rchk(`PML_FDT4_OFS, de[k]);
    end
    apb(1'b1, `PML_CFG_OFS, 32'h6);
    rchk(`PML_CFG_OFS, 0);
    // same duty table for channels one and two, frequency table for three
    for (int k = 0; k < 4; k++) begin
      for (int t = 0; t < 2; t++) begin
        apb(1'b1, 12'h400 + 12'(t * 256 + 4 * k), 32'(xbp[k]));
        apb(1'b1, 12'h410 + 12'(t * 256 + 4 * k), 32'(ybp[k]));
        for (int x = 0; x < 4; x++)
          apb(1'b1, 12'h440 + 12'(t * 256 + 16 * k + 4 * x), 32'(10 + 20 * k + 5 * x));
      end
      apb(1'b1, 12'h600 + 12'(4 * k), 32'(fbp[k]));
      apb(1'b1, 12'h640 + 12'(4 * k), 32'(fmap[k]));
    end
    ev <= 4'hf;
    // duty lookup: channel one single axis, channel two both axes, every duty type
    for (int it = 0; it < 8; it++) begin
      typ = 2 + it % 4;
      ve = $urandom_range(9000);
      vt = $urandom_range(120);
      apb(1'b1, `PML_CFG_OFS, 32'h340 + 32'(typ));
      apb(1'b1, `PML_CFG_OFS + 12'h4, 32'hf40 + 32'(typ));
      eng <= 16'(ve);
      thr <= 16'(vt);
      aux_b <= 16'($urandom);
      repeat (400) @(posedge pclk);
      e0 = 10 + axv(ve, xbp, typ, 5);
      e1 = e0 + axv(vt, ybp, typ, 20);
      rchk(`PML_DUTY_OFS, e0);
      rchk(`PML_DUTY_OFS + 12'h4, e1);
      meas(200);
      `CHK(cnt[0], hic(200, e0))
      `CHK(cnt[1], hic(200, e1))
    end
    // applied frequency is clamped; both channels keep one period
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, `PML_FRQ12_OFS, 32'(fr[k]));
      per = CLK / (fr[k] > 15000 ? 15000 : 30);
      repeat (400 + per) @(posedge pclk);
      meas(per);
      `CHK(cnt[0], hic(per, e0))
      `CHK(cnt[1], hic(per, e1))
    end
    // frequency mode on channel three, axis on aux input a, duty fixed at 40, stepped types
    apb(1'b1, `PML_FDT3_OFS, 32'h28);
    for (int it = 0; it < 4; it++) begin
      va = $urandom_range(900);
      apb(1'b1, `PML_CFG_OFS + 12'h8, 32'h327 + 32'(it % 3));
      aux_a <= 16'(va);
      per = CLK / fmap[pick(va, fbp, 4, 3 + it % 3)];
      repeat (400 + per) @(posedge pclk);
      meas(per);
      `CHK(cnt[2], hic(per, 40))
    end
    // digital type is on while its event is on, disabled type stays off
    apb(1'b1, `PML_CFG_OFS + 12'hc, 32'h1);
    meas(400);
    `CHK(outs[3], 1'b1)
    apb(1'b1, `PML_CFG_OFS + 12'hc, 32'h0);
    meas(400);
    `CHK(cnt[3], 0)
    // manual mode overrides running pwm; each command toggles
    apb(1'b1, `PML_CTRL_OFS, 32'h1);
    meas(200);
    `CHK(cnt[0] + cnt[1] + cnt[2], 0)
    st = 0;
    for (int it = 0; it < 6; it++) begin
      m = $urandom_range(15);
      apb(1'b1, `PML_MCMD_OFS, 32'(m));
      st = st ^ m;
      rchk(`PML_MCMD_OFS, st);
      `CHK(outs, 4'(st))
    end
    apb(1'b1, `PML_MCMD_OFS, 32'(~st & 15));
    repeat (8) @(posedge pclk);
    for (int k = 0; k < 4; k++) rchk(`PML_CUR_OFS + 12'(4 * k), BASE + 100 * k);
    apb(1'b1, `PML_CTRL_OFS, 32'h0);
    conclude();
  end
endmodule
